/* File: core/sarc_pkg.sv */
// package: register map, field layout, timing and types for the sar converter control
package sarc_pkg;
    localparam int ADDR_W = 2;
    localparam logic [1:0] OFF_CSR = 2'h0;
    localparam logic [1:0] OFF_RES_UP = 2'h1;
    localparam logic [1:0] OFF_RES_LO = 2'h2;
    localparam int BIT_DONE = 7;
    localparam int BIT_SPEED = 6;
    localparam int BIT_ON = 5;
    localparam int BIT_RSVD = 4;
    localparam int CH_MSB = 3;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;
    localparam int RES_W = 10;
    localparam logic [9:0] RES_FULL = 10'h3ff;
    localparam logic [9:0] RES_ZERO = 10'h000;
    localparam int DIV_SLOW = 4;
    localparam int DIV_FAST = 2;
    // one sample slot plus one slot per result bit
    localparam int SAMPLE_SLOTS = 1;
    localparam int CLK_MHZ = 25;
    localparam int STAB_NS = 10000;
    localparam int STAB_CYC_CALC = (STAB_NS * CLK_MHZ + 999) / 1000;
    localparam int STAB_CYC = (STAB_CYC_CALC < 1) ? 1 : STAB_CYC_CALC;

    typedef struct packed {
        logic speed;
        logic on;
        logic [3:0] channel;
    } sarc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [9:0] code;
    } sarc_result_t;

    typedef enum logic [3:0] {
        SARC_OFF = 4'b0001,
        SARC_STAB = 4'b0010,
        SARC_SAMPLE = 4'b0100,
        SARC_CONV = 4'b1000
    } sarc_state_t;
endpackage

/* File: core/sarc_clkdiv.sv */
// converter clock tick generator: cpu clock divided by 4 or by 2
`timescale 1ns/1ps
module sarc_clkdiv
    import sarc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic run,
    input wire logic fast,
    output logic tick
);
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    wire logic [1:0] last_cnt;
    wire logic wrap;

    assign last_cnt = fast ? 2'(DIV_FAST - 1) : 2'(DIV_SLOW - 1);
    assign wrap = (cnt_ff >= last_cnt);
    assign nxt_cnt = (!run || wrap) ? 2'h0 : cnt_ff + 2'h1;
    assign tick = run && wrap;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            cnt_ff <= 2'h0;
        else if (clk_en)
            cnt_ff <= nxt_cnt;
    end
endmodule

/* File: core/sarc_sar.sv */
// successive approximation register: one trial bit per converter tick
`timescale 1ns/1ps
module sarc_sar
    import sarc_pkg::*;
#(
    parameter int WIDTH = RES_W
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic abort,
    input wire logic tick,
    input wire logic cmp_hi,
    output logic [WIDTH-1:0] dac_code,
    output logic busy,
    output logic done,
    output logic [WIDTH-1:0] code
);
    logic [WIDTH-1:0] sar_ff;
    logic [WIDTH-1:0] bit_ff;
    logic [WIDTH-1:0] code_ff;
    logic done_ff;
    wire logic [WIDTH-1:0] kept;
    wire logic last;

    // trial code is the settled bits plus the bit under test
    assign dac_code = sar_ff | bit_ff;
    // keep the trial bit only when the input lies at or above it
    assign kept = cmp_hi ? dac_code : sar_ff;
    assign last = bit_ff[0];
    assign busy = |bit_ff;
    assign done = done_ff;
    assign code = code_ff;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sar_ff <= '0;
            bit_ff <= '0;
            code_ff <= '0;
            done_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            done_ff <= 1'b0;
            if (abort)
            begin
                sar_ff <= '0;
                bit_ff <= '0;
            end
            else if (start)
            begin
                sar_ff <= '0;
                bit_ff <= {1'b1, {(WIDTH-1){1'b0}}};
            end
            else if (tick && busy)
            begin
                sar_ff <= kept;
                bit_ff <= bit_ff >> 1;
                if (last)
                begin
                    code_ff <= kept;
                    done_ff <= 1'b1;
                end
            end
        end
    end
endmodule

/* File: core/sarc_top.sv */
// sar converter control: registers, sequencing, clamping and low-power handling
`timescale 1ns/1ps
module sarc_top
    import sarc_pkg::*;
#(
    parameter int WIDTH = RES_W,
    parameter int STAB_CYCLES = STAB_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cmp_hi,
    input wire logic over_high_ref,
    input wire logic under_low_ref,
    output logic [3:0] channel_select,
    output logic sample_hold,
    output logic analog_enable,
    output logic [WIDTH-1:0] dac_code,
    output logic converter_ready
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // comparator answers this clock's own trial code within the cycle, so it is read directly;
    // two extra flops would outlast a divide-by-2 bit slot and decide on a stale trial
    logic [1:0] over_sync_ff;
    logic [1:0] under_sync_ff;
    logic [1:0] halt_sync_ff;
    logic [1:0] wait_sync_ff;
    wire logic over_s;
    wire logic under_s;
    wire logic halt_s;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            over_sync_ff <= 2'h0;
            under_sync_ff <= 2'h0;
            halt_sync_ff <= 2'h0;
            wait_sync_ff <= 2'h0;
        end
        else if (clk_en)
        begin
            over_sync_ff <= {over_sync_ff[0], over_high_ref};
            under_sync_ff <= {under_sync_ff[0], under_low_ref};
            halt_sync_ff <= {halt_sync_ff[0], halt_mode};
            wait_sync_ff <= {wait_sync_ff[0], wait_mode};
        end
    end

    assign over_s = over_sync_ff[1];
    assign under_s = under_sync_ff[1];
    assign halt_s = halt_sync_ff[1];

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    // address match shared by the write decode, the read clear and the read mux
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return (a == off);
    endfunction

    sarc_cfg_t cfg_ff;
    logic done_flag_ff;
    logic [WIDTH-1:0] result_ff;
    logic [7:0] rdata_ff;
    wire logic wr_csr;
    wire logic rd_upper;
    wire logic ch_change;
    wire logic conv_done;
    wire logic [WIDTH-1:0] sar_code;
    wire logic [WIDTH-1:0] clamped;
    wire logic [7:0] csr_view;
    wire logic [7:0] upper_view;
    wire logic [7:0] lower_view;
    wire logic [7:0] nxt_rdata;
    sarc_cfg_t nxt_cfg;

    assign wr_csr = wr_en && reg_hit(addr, OFF_CSR);
    assign rd_upper = rd_en && reg_hit(addr, OFF_RES_UP);
    assign ch_change = wr_csr && (wdata[CH_MSB:0] != cfg_ff.channel);
    // reserved bit 4 is not stored and reads zero
    assign nxt_cfg = wr_csr ? sarc_cfg_t'{speed: wdata[BIT_SPEED], on: wdata[BIT_ON], channel: wdata[CH_MSB:0]}
                            : cfg_ff;

    assign csr_view = {done_flag_ff, cfg_ff.speed, cfg_ff.on, 1'b0, cfg_ff.channel};
    assign upper_view = result_ff[WIDTH-1:WIDTH-8];
    assign lower_view = {6'h00, result_ff[1:0]};
    assign nxt_rdata = !rd_en ? 8'h00 :
                       reg_hit(addr, OFF_CSR) ? csr_view :
                       reg_hit(addr, OFF_RES_UP) ? upper_view :
                       reg_hit(addr, OFF_RES_LO) ? lower_view : 8'h00;
    assign rdata = rdata_ff;

    // out-of-range flags from the front end override the sar code
    assign clamped = over_s ? RES_FULL : (under_s ? RES_ZERO : sar_code);

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfg_ff <= '{speed: CSR_RESET[BIT_SPEED], on: CSR_RESET[BIT_ON], channel: CSR_RESET[CH_MSB:0]};
            rdata_ff <= 8'h00;
            result_ff <= {RES_RESET, 2'h0};
        end
        else if (clk_en)
        begin
            cfg_ff <= nxt_cfg;
            rdata_ff <= nxt_rdata;
            if (conv_done)
                result_ff <= clamped;
        end
    end

    // set wins over a same-cycle read or write clear
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            done_flag_ff <= 1'b0;
        else if (clk_en)
        begin
            if (conv_done)
                done_flag_ff <= 1'b1;
            else if (rd_upper || wr_csr)
                done_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    sarc_state_t state_ff;
    sarc_state_t nxt_state;
    logic [15:0] stab_cnt_ff;
    logic [15:0] nxt_stab_cnt;
    wire logic enabled;
    wire logic tick;
    wire logic start_conv;
    wire logic abort_conv;
    wire logic stab_done;

    // wait mode is intentionally ignored; the on bit and halt gate the converter
    assign enabled = cfg_ff.on && !halt_s;
    assign stab_done = (stab_cnt_ff >= 16'(STAB_CYCLES - 1));
    assign abort_conv = !enabled || ch_change;
    assign start_conv = (state_ff == SARC_SAMPLE) && tick && !abort_conv;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_stab_cnt = 16'h0000;
        unique case (state_ff)
            SARC_OFF:
                if (enabled)
                    nxt_state = SARC_STAB;
            SARC_STAB:
            begin
                nxt_stab_cnt = stab_cnt_ff + 16'h0001;
                if (!enabled)
                    nxt_state = SARC_OFF;
                else if (stab_done)
                    nxt_state = SARC_SAMPLE;
            end
            SARC_SAMPLE:
                if (!enabled)
                    nxt_state = SARC_OFF;
                else if (start_conv)
                    nxt_state = SARC_CONV;
            SARC_CONV:
                if (!enabled)
                    nxt_state = SARC_OFF;
                else if (ch_change || conv_done)
                    nxt_state = SARC_SAMPLE;
            default:
                nxt_state = SARC_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= SARC_OFF;
            stab_cnt_ff <= 16'h0000;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            stab_cnt_ff <= nxt_stab_cnt;
        end
    end

    sarc_clkdiv u_clkdiv (
        .clk_sys(clk_sys),
        .rst(rst),
        .clk_en(clk_en),
        .run(enabled),
        .fast(cfg_ff.speed),
        .tick(tick)
    );

    sarc_sar #(.WIDTH(WIDTH)) u_sar (
        .clk_sys(clk_sys),
        .rst(rst),
        .clk_en(clk_en),
        .start(start_conv),
        .abort(abort_conv),
        .tick(tick),
        .cmp_hi(cmp_hi),
        .dac_code(dac_code),
        .busy(),
        .done(conv_done),
        .code(sar_code)
    );

    // ----------------------------------------------------------------
    // analog front-end controls
    // ----------------------------------------------------------------
    assign channel_select = cfg_ff.channel;
    // gated by enabled so a stop or halt drops them together with the front end, not a cycle later
    assign sample_hold = (state_ff == SARC_SAMPLE) && enabled;
    assign analog_enable = enabled;
    assign converter_ready = ((state_ff == SARC_SAMPLE) || (state_ff == SARC_CONV)) && enabled;
    // no interrupt output by design; software polls the done flag
endmodule

/* File: dv/sarc_analog_model.sv */
// analog front end model: selected input level against the trial code
`timescale 1ns/1ps
module sarc_analog_model
(
    input wire logic analog_enable,
    input wire logic [9:0] dac_code,
    input wire logic signed [31:0] level,
    output logic cmp_hi,
    output logic over_high_ref,
    output logic under_low_ref
);
    // comparator gives nothing while the front end is powered down
    assign cmp_hi = analog_enable && (level >= int'(dac_code));
    assign over_high_ref = level > 1023;
    assign under_low_ref = level < 0;
endmodule

/* File: dv/sarc_top_properties.sv */
// port assertions for the converter control
`timescale 1ns/1ps
module sarc_top_properties
    import sarc_pkg::*;
#(
    parameter int WIDTH = RES_W,
    parameter int STAB_CYCLES = STAB_CYC
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic cmp_hi,
    input wire logic over_high_ref,
    input wire logic under_low_ref,
    input wire logic [3:0] channel_select,
    input wire logic sample_hold,
    input wire logic analog_enable,
    input wire logic [WIDTH-1:0] dac_code,
    input wire logic converter_ready
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire csr_wr = clk_en && wr_en && addr == OFF_CSR;

    rdata_idle_a: assert property (clk_en && !rd_en |=> rdata == 8'h00)
        else $error("read data not idle");
    lower_pad_a: assert property (clk_en && rd_en && addr == OFF_RES_LO |=> rdata[7:2] == 6'h00)
        else $error("lower result padding not zero");
    csr_rsvd_a: assert property (clk_en && rd_en && addr == OFF_CSR |=> !rdata[BIT_RSVD])
        else $error("reserved status bit set");
    unmapped_read_a: assert property (clk_en && rd_en && addr == 2'h3 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chan_follow_a: assert property (csr_wr |=> channel_select == $past(wdata[3:0]))
        else $error("channel does not follow write");
    off_stops_a: assert property (csr_wr && !wdata[BIT_ON] |=> !analog_enable && !sample_hold)
        else $error("converter still on after off write");
    halt_off_a: assert property ((clk_en && halt_mode) [*3] |-> !analog_enable && !converter_ready)
        else $error("converter on during halt");
    stab_wait_a: assert property ($rose(analog_enable) |-> !converter_ready [*2])
        else $error("ready without stabilization");
    sample_on_a: assert property (sample_hold |=> sample_hold || !analog_enable || dac_code[WIDTH-1])
        else $error("sample not followed by msb trial");

    cover property (sample_hold);
    cover property (rd_en && addr == OFF_CSR ##1 rdata[BIT_DONE]);
    cover property (halt_mode && !analog_enable);
endmodule

bind sarc_top sarc_top_properties #(.WIDTH(WIDTH), .STAB_CYCLES(STAB_CYCLES)) sarc_top_properties_inst (.clk_sys,
    .rst, .clk_en, .addr, .wdata, .wr_en, .rd_en, .rdata, .halt_mode, .wait_mode, .cmp_hi, .over_high_ref,
    .under_low_ref, .channel_select, .sample_hold, .analog_enable, .dac_code, .converter_ready);

/* File: dv/sarc_top_test.sv */
// self-checking bench for the converter control
`timescale 1ns/1ps
module sarc_top_test
    import sarc_pkg::*;
;
    logic clk_sys, rst, clk_en, wr_en, rd_en, halt_mode, wait_mode, cmp_hi, over_high_ref, under_low_ref;
    logic sample_hold, analog_enable, converter_ready;
    logic [1:0] addr;
    logic [7:0] wdata, rdata;
    logic [3:0] channel_select;
    logic [9:0] dac_code;
    int level, mismatches, compares;

    function automatic int lvl(input logic [3:0] ch);
        if (ch == 4'he)
            return 1100;
        if (ch == 4'hf)
            return -5;
        return ch * 73 + 1;
    endfunction

    function automatic logic [9:0] exp_code(input logic [3:0] ch);
        if (lvl(ch) > 1023)
            return RES_FULL;
        if (lvl(ch) < 0)
            return RES_ZERO;
        return 10'(lvl(ch));
    endfunction

    always_comb level = lvl(channel_select);

    sarc_top #(.STAB_CYCLES(4)) sarc_top_inst (.clk_sys, .rst, .clk_en, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .halt_mode, .wait_mode, .cmp_hi, .over_high_ref, .under_low_ref, .channel_select, .sample_hold,
        .analog_enable, .dac_code, .converter_ready);
    sarc_analog_model sarc_analog_model_inst (.analog_enable, .dac_code, .level, .cmp_hi, .over_high_ref,
        .under_low_ref);

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    // polls the done flag; a flag that never comes ends the run
    task automatic wait_done(output int n);
        logic [7:0] d;
        n = 0;
        d = 8'h00;
        while (d[BIT_DONE] !== 1'b1 && n < 200)
        begin
            rd(OFF_CSR, d);
            n++;
        end
        check("done flag", 10'h001, {9'h0, d[BIT_DONE]});
        if (d[BIT_DONE] !== 1'b1)
            finish_test();
    endtask

    task automatic convert(input logic [3:0] ch, input logic sp, output logic [9:0] code, output int n);
        logic [7:0] lo, up;
        wr(OFF_CSR, {1'b0, sp, 1'b1, 1'b0, ch});
        wait_done(n);
        rd(OFF_RES_LO, lo);
        rd(OFF_RES_UP, up);
        code = {up, lo[1:0]};
        check("lower padding", 10'h000, {4'h0, lo[7:2]});
        rd(OFF_CSR, lo);
        check("done after upper read", 10'h000, {9'h0, lo[BIT_DONE]});
    endtask

    // nothing may complete while the converter is off or halted
    task automatic quiet();
        logic [7:0] d;
        repeat (60)
        begin
            rd(OFF_CSR, d);
            check("done while stopped", 10'h000, {9'h0, d[BIT_DONE]});
        end
    endtask

    task automatic reset_values();
        logic [7:0] d;
        for (int a = 0; a < 4; a++)
        begin
            rd(a[1:0], d);
            check("reset value", 10'h000, {2'b00, d});
        end
        wr(2'h3, 8'hff);
        wr(OFF_RES_UP, 8'hff);
        wr(OFF_CSR, 8'h8f);
        rd(OFF_CSR, d);
        check("status readback", 10'h00f, {2'b00, d});
        rd(OFF_RES_UP, d);
        check("result write ignored", 10'h000, {2'b00, d});
    endtask

    task automatic sweep();
        logic [9:0] code, prev;
        int n;
        prev = 10'h000;
        for (int c = 0; c < 16; c++)
        begin
            convert(c[3:0], c[0], code, n);
            check("result", exp_code(c[3:0]), code);
            // inputs rise up to channel 14 and fall at channel 15
            check("monotonic", 10'h001, {9'h0, (c == 15) ? (code <= prev) : (code >= prev)});
            prev = code;
        end
    endtask

    task automatic speed_and_change();
        logic [9:0] code;
        int ns, nf;
        logic [7:0] d;
        wr(OFF_CSR, 8'h00);
        convert(4'h3, 1'b0, code, ns);
        wr(OFF_CSR, 8'h00);
        convert(4'h3, 1'b1, code, nf);
        check("slow longer", 10'h001, {9'h0, ns > nf + 4});
        wr(OFF_CSR, 8'h22);
        repeat (20) @(posedge clk_sys);
        convert(4'h9, 1'b0, code, ns);
        check("result after change", exp_code(4'h9), code);
        wait_done(ns);
        rd(OFF_RES_UP, d);
        check("upper byte only", exp_code(4'h9) >> 2, {2'b00, d});
        rd(OFF_CSR, d);
        check("done after 8-bit read", 10'h000, {9'h0, d[BIT_DONE]});
        wait_done(ns);
        wr(OFF_CSR, 8'h29);
        quiet_one();
    endtask

    task automatic quiet_one();
        logic [7:0] d;
        rd(OFF_CSR, d);
        check("done after status write", 10'h000, {9'h0, d[BIT_DONE]});
    endtask

    task automatic power_modes();
        logic [9:0] code;
        int n;
        wr(OFF_CSR, 8'h25);
        wr(OFF_CSR, 8'h05);
        quiet();
        @(posedge clk_sys);
        wait_mode <= 1'b1;
        convert(4'h5, 1'b0, code, n);
        check("result in wait", exp_code(4'h5), code);
        @(posedge clk_sys);
        wait_mode <= 1'b0;
        halt_mode <= 1'b1;
        wr(OFF_CSR, 8'h25);
        quiet();
        @(posedge clk_sys);
        halt_mode <= 1'b0;
        convert(4'h7, 1'b1, code, n);
        check("result after halt", exp_code(4'h7), code);
    endtask

    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        addr = 2'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        halt_mode = 1'b0;
        wait_mode = 1'b0;
        mismatches = 0;
        compares = 0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        reset_values();
        sweep();
        speed_and_change();
        power_modes();
        finish_test();
    end
endmodule
